//--- rtl/epv_pkg.sv
// package: constants, types and mode decode of the program/verify port
// Notes on behaviour
// - Reset pin high, store enable low; four port bits pick the mode.
// - Strobe idles high in read modes; program modes need the high voltage.
// - Verify mode drives the addressed code byte onto port 0.
// - Verify data is code byte XNOR one encryption table byte.
// - Table contents are never readable.
// - Identification bytes come out at 030 and 031 in signature mode.
// - Any lock bit blocks code and table writes, not other lock bits.
// - Lock one blocks external table reads, latches access level, stops writes.
// - Lock two adds a ban on verify mode.
// - Lock three also bans external execution and internal data RAM.
// - Other lock combinations act as the highest lock bit set.
// - Erased code array reads back as all ones.
// - Table holds 64 bytes, erased to all ones, so XNOR changes nothing.
package epv_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PROG_LOW_MIN_CYC = 18000; // 90 us in 5 ns cycles
  localparam logic [2:0] PROG_PULSES = 3'h5;
  localparam int LOW_CNT_W = 16;

  // ----------------------------------------------------------------
  // arrays and fixed values
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int CODE_AW = 12;
  localparam int ENC_AW = 6;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [11:0] SIG_ADDR0 = 12'h030;
  localparam logic [11:0] SIG_ADDR1 = 12'h031;
  localparam logic [11:0] CODE_LAST = 12'hFFF;
  localparam logic [11:0] ENC_SIZE = 12'h040;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_TADDR = 4'h8;
  localparam logic [3:0] REG_TDATA = 4'hC;
  localparam int ST_LOCK_LSB = 0;
  localparam int ST_BUSY = 4;
  localparam int ST_REFUSED = 5;
  localparam int ST_EA = 6;
  localparam int ST_PULSE_LSB = 8;
  localparam int CTRL_ERASE = 0;
  localparam int CTRL_CLR_REFUSED = 1;
  localparam int TA_EXT = 16;
  localparam int TD_BLOCKED = 8;
  localparam logic [11:0] TADDR_RST = 12'h000;
  localparam logic [2:0] LOCK_ERASED = 3'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NONE = 3'b000,
    MODE_SIG = 3'b001,
    MODE_PGM_CODE = 3'b010,
    MODE_VERIFY = 3'b011,
    MODE_PGM_ENC = 3'b100,
    MODE_LOCK1 = 3'b101,
    MODE_LOCK2 = 3'b110,
    MODE_LOCK3 = 3'b111
  } epv_mode_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_MEM1 = 2'b01,
    BUS_MEM2 = 2'b10,
    BUS_ACK = 2'b11
  } epv_bus_st_t;

  typedef struct packed {
    logic reset_pin;
    logic program_store_enable;
    logic address_latch_program_strobe;
    logic external_access_program_voltage;
    logic external_access_level;
    logic port2_bit_seven;
    logic port2_bit_six;
    logic port3_bit_seven;
    logic port3_bit_six;
    logic [3:0] port2_addr;
    logic [7:0] port1;
    logic [7:0] port0_in;
  } epv_pins_t;

  typedef struct packed {
    epv_mode_t mode;
    logic [11:0] addr;
    logic [7:0] data;
  } epv_snap_t;

  // mode from static pin levels; program modes need the high voltage
  function automatic epv_mode_t epv_decode(input epv_pins_t p);
    epv_mode_t m;
    m = MODE_NONE;
    if (p.reset_pin && !p.program_store_enable) begin
      case ({p.port2_bit_seven, p.port2_bit_six,
             p.port3_bit_seven, p.port3_bit_six})
        4'h0: m = MODE_SIG;
        4'hB: m = MODE_PGM_CODE;
        4'h3: m = MODE_VERIFY;
        4'hA: m = MODE_PGM_ENC;
        4'hF: m = MODE_LOCK1;
        4'hC: m = MODE_LOCK2;
        4'h5: m = MODE_LOCK3;
        default: m = MODE_NONE;
      endcase
      if (m == MODE_SIG || m == MODE_VERIFY) begin
        if (p.external_access_program_voltage || !p.external_access_level) begin
          m = MODE_NONE;
        end
      end else if (m != MODE_NONE && !p.external_access_program_voltage) begin
        m = MODE_NONE;
      end
    end
    return m;
  endfunction : epv_decode

  function automatic logic epv_is_prog(input epv_mode_t m);
    return (m != MODE_NONE) && (m != MODE_SIG) && (m != MODE_VERIFY);
  endfunction : epv_is_prog

endpackage : epv_pkg

//--- rtl/epv_mem.sv
// file: single-port-write, registered-read byte memory
`timescale 1ns/1ps
module epv_mem #(
  parameter int DW = 8,
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  // array starts erased, every bit set; one writer keeps a single driver
  logic [DW-1:0] mem [0:(1<<AW)-1] = '{default: '1};

  // no reset on the array: contents are nonvolatile
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule : epv_mem

//--- rtl/epv_strobe.sv
// file: program strobe pulse qualifier and five-pulse counter
`timescale 1ns/1ps
module epv_strobe
  import epv_pkg::*;
#(
  parameter int LOW_MIN = PROG_LOW_MIN_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic strobe,
  input wire logic arm,
  input wire logic restart,
  output logic fall,
  output logic done,
  output logic [2:0] count
);

  logic prev;
  logic [LOW_CNT_W-1:0] low_cnt;
  logic next_prev;
  logic next_done;
  logic [2:0] next_count;
  logic [LOW_CNT_W-1:0] next_low_cnt;

  assign fall = prev && !strobe;

  // ----------------------------------------------------------------
  // pulse counting
  // ----------------------------------------------------------------
  // short glitches never count: a pulse must reach the minimum low time
  always_comb begin
    next_prev = strobe;
    next_done = 1'b0;
    next_count = count;
    next_low_cnt = low_cnt;
    if (!strobe) begin
      if (low_cnt != '1) begin
        next_low_cnt = low_cnt + 1'b1;
      end
    end else begin
      next_low_cnt = '0;
    end
    if (fall && restart) begin
      next_count = 3'h0;
    end
    if (!prev && strobe && low_cnt >= LOW_CNT_W'(LOW_MIN)) begin
      if (count + 3'h1 == PROG_PULSES) begin
        next_count = 3'h0;
        next_done = 1'b1;
      end else begin
        next_count = count + 3'h1;
      end
    end
    if (!arm) begin
      next_count = 3'h0;
      next_done = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b1;
      done <= 1'b0;
      count <= 3'h0;
      low_cnt <= '0;
    end else if (ce) begin
      prev <= next_prev;
      done <= next_done;
      count <= next_count;
      low_cnt <= next_low_cnt;
    end
  end

endmodule : epv_strobe

//--- rtl/epv_top.sv
// file: code memory program/verify port with security bits and bus slave
`timescale 1ns/1ps
module epv_top #(
  parameter int PROG_LOW_MIN = epv_pkg::PROG_LOW_MIN_CYC,
  parameter logic [7:0] ID_BYTE0 = 8'hA5, // arbitrary identity value
  parameter logic [7:0] ID_BYTE1 = 8'h5A  // arbitrary identity value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire epv_pkg::epv_pins_t pins,
  output logic [7:0] port0_out,
  output logic port0_oe,
  output logic ea_effective,
  output logic table_read_blocked,
  output logic exec_external_disable,
  output logic data_ram_deny,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import epv_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  epv_mode_t live_mode;
  epv_snap_t live_snap, snap, next_snap;
  epv_bus_st_t bus_st, next_bus_st;
  logic arm, restart, fall, done;
  logic [2:0] pulse_cnt;
  logic [2:0] lock = LOCK_ERASED; // nonvolatile, erased at start
  logic [2:0] next_lock;
  logic refused, next_refused;
  logic erase_busy, next_erase_busy;
  logic [11:0] erase_cnt, next_erase_cnt;
  logic [11:0] taddr, next_taddr;
  logic taddr_ext, next_taddr_ext;
  logic next_waitreq;
  logic [31:0] next_rdata, reg_rdata, tdata_word;
  logic bus_wr, ctrl_wr, lock_any, verify_dis, ext_dis, tbl_block;
  logic code_we, enc_we;
  logic [11:0] code_waddr, code_raddr;
  logic [5:0] enc_waddr;
  logic [7:0] code_wdata, enc_wdata, code_rd, enc_rd;
  logic ea_latched, ea_caught, next_ea_latched, next_ea_caught;
  logic [7:0] next_p0_out;
  logic next_p0_oe;

  // ----------------------------------------------------------------
  // pin decode and protection levels
  // ----------------------------------------------------------------
  assign live_mode = epv_decode(pins);
  assign live_snap = '{mode: live_mode,
                       addr: {pins.port2_addr, pins.port1},
                       data: pins.port0_in};
  assign arm = epv_is_prog(live_mode);
  // a changed address, data or mode between pulses starts a new byte
  assign restart = (pulse_cnt != 3'h0) && (live_snap != snap);
  assign lock_any = |lock;
  assign verify_dis = lock[1] | lock[2];
  assign ext_dis = lock[2];
  assign tbl_block = lock_any && taddr_ext;

  epv_strobe #(
    .LOW_MIN(PROG_LOW_MIN)
  ) u_strobe (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .strobe(pins.address_latch_program_strobe),
    .arm(arm),
    .restart(restart),
    .fall(fall),
    .done(done),
    .count(pulse_cnt)
  );

  // ----------------------------------------------------------------
  // memories
  // ----------------------------------------------------------------
  // one read port: the bus borrows it for a single cycle per table read
  assign code_raddr = (bus_st == BUS_MEM1) ? taddr : live_snap.addr;

  epv_mem #(
    .DW(DATA_W),
    .AW(CODE_AW)
  ) u_code (
    .clk(clk),
    .ce(ce),
    .we(code_we),
    .waddr(code_waddr),
    .wdata(code_wdata),
    .raddr(code_raddr),
    .rdata(code_rd)
  );

  epv_mem #(
    .DW(DATA_W),
    .AW(ENC_AW)
  ) u_enc (
    .clk(clk),
    .ce(ce),
    .we(enc_we),
    .waddr(enc_waddr),
    .wdata(enc_wdata),
    .raddr(live_snap.addr[5:0]),
    .rdata(enc_rd)
  );

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  // table bytes never reach the bus, only code bytes
  always_comb begin
    reg_rdata = 32'h0;
    tdata_word = 32'h0;
    tdata_word[TD_BLOCKED] = tbl_block;
    tdata_word[7:0] = tbl_block ? 8'h00 : code_rd;
    case (avs_address)
      REG_STATUS: begin
        reg_rdata[ST_LOCK_LSB +: 3] = lock;
        reg_rdata[ST_BUSY] = erase_busy;
        reg_rdata[ST_REFUSED] = refused;
        reg_rdata[ST_EA] = ea_latched;
        reg_rdata[ST_PULSE_LSB +: 3] = pulse_cnt;
      end
      REG_TADDR: begin
        reg_rdata[11:0] = taddr;
        reg_rdata[TA_EXT] = taddr_ext;
      end
      default: reg_rdata = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // writes land at the edge where waitrequest is seen low
  assign bus_wr = (bus_st == BUS_ACK) && avs_write;
  assign ctrl_wr = bus_wr && (avs_address == REG_CTRL) && avs_byteenable[0];

  always_comb begin
    next_bus_st = bus_st;
    next_waitreq = avs_waitrequest;
    next_rdata = avs_readdata;
    next_taddr = taddr;
    next_taddr_ext = taddr_ext;
    case (bus_st)
      BUS_IDLE: begin
        if (avs_read && avs_address == REG_TDATA) begin
          next_bus_st = BUS_MEM1;
        end else if (avs_read || avs_write) begin
          next_bus_st = BUS_ACK;
          next_waitreq = 1'b0;
          next_rdata = avs_read ? reg_rdata : 32'h0;
        end
      end
      BUS_MEM1: next_bus_st = BUS_MEM2;
      BUS_MEM2: begin
        next_bus_st = BUS_ACK;
        next_waitreq = 1'b0;
        next_rdata = tdata_word;
      end
      BUS_ACK: begin
        next_bus_st = BUS_IDLE;
        next_waitreq = 1'b1;
      end
      default: begin
        next_bus_st = BUS_IDLE;
        next_waitreq = 1'b1;
      end
    endcase
    if (bus_wr && avs_address == REG_TADDR) begin
      if (avs_byteenable[0]) next_taddr[7:0] = avs_writedata[7:0];
      if (avs_byteenable[1]) next_taddr[11:8] = avs_writedata[11:8];
      if (avs_byteenable[2]) next_taddr_ext = avs_writedata[TA_EXT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_st <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      taddr <= TADDR_RST;
      taddr_ext <= 1'b0;
    end else if (ce) begin
      bus_st <= next_bus_st;
      avs_waitrequest <= next_waitreq;
      avs_readdata <= next_rdata;
      taddr <= next_taddr;
      taddr_ext <= next_taddr_ext;
    end
  end

  // ----------------------------------------------------------------
  // programming, locks and erase
  // ----------------------------------------------------------------
  always_comb begin
    next_snap = snap;
    next_lock = lock;
    next_refused = refused;
    next_erase_busy = erase_busy;
    next_erase_cnt = erase_cnt;
    code_we = 1'b0;
    code_waddr = snap.addr;
    code_wdata = snap.data;
    enc_we = 1'b0;
    enc_waddr = snap.addr[5:0];
    enc_wdata = snap.data;
    if (fall && arm) begin
      next_snap = live_snap;
    end
    if (ctrl_wr && avs_writedata[CTRL_CLR_REFUSED]) begin
      next_refused = 1'b0;
    end
    // commit only if the mode still stands as it was captured
    if (done && live_mode == snap.mode && !erase_busy) begin
      case (snap.mode)
        MODE_PGM_CODE: begin
          if (lock_any) next_refused = 1'b1;
          else code_we = 1'b1;
        end
        MODE_PGM_ENC: begin
          if (lock_any) next_refused = 1'b1;
          else enc_we = 1'b1;
        end
        MODE_LOCK1: next_lock[0] = 1'b1;
        MODE_LOCK2: next_lock[1] = 1'b1;
        MODE_LOCK3: next_lock[2] = 1'b1;
        default: next_refused = refused;
      endcase
    end else if (done) begin
      next_refused = 1'b1;
    end
    // erase sweeps both arrays back to all ones
    if (erase_busy) begin
      code_we = 1'b1;
      code_waddr = erase_cnt;
      code_wdata = ERASED_BYTE;
      enc_we = erase_cnt < ENC_SIZE;
      enc_waddr = erase_cnt[5:0];
      enc_wdata = ERASED_BYTE;
      next_erase_cnt = erase_cnt + 12'h001;
      if (erase_cnt == CODE_LAST) next_erase_busy = 1'b0;
    end else if (ctrl_wr && avs_writedata[CTRL_ERASE]) begin
      next_erase_busy = 1'b1;
      next_erase_cnt = 12'h000;
      next_lock = LOCK_ERASED;
    end
  end

  // lock bits are nonvolatile and so ride through reset
  always_ff @(posedge clk) begin
    if (ce) begin
      lock <= next_lock;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snap <= '0;
      refused <= 1'b0;
      erase_busy <= 1'b0;
      erase_cnt <= 12'h000;
    end else if (ce) begin
      snap <= next_snap;
      refused <= next_refused;
      erase_busy <= next_erase_busy;
      erase_cnt <= next_erase_cnt;
    end
  end

  // ----------------------------------------------------------------
  // port 0 and protection outputs
  // ----------------------------------------------------------------
  // port 0 drives the whole byte while enabled; the board pull-ups hold it high otherwise
  always_comb begin
    next_p0_out = port0_out;
    next_p0_oe = 1'b0;
    next_ea_latched = ea_latched;
    next_ea_caught = 1'b1;
    if (!ea_caught) begin
      next_ea_latched = pins.external_access_level;
    end
    if (live_mode == MODE_SIG) begin
      if (live_snap.addr == SIG_ADDR0) begin
        next_p0_out = ID_BYTE0;
        next_p0_oe = 1'b1;
      end else if (live_snap.addr == SIG_ADDR1) begin
        next_p0_out = ID_BYTE1;
        next_p0_oe = 1'b1;
      end
    end else if (live_mode == MODE_VERIFY && !verify_dis) begin
      next_p0_out = ~(code_rd ^ enc_rd);
      next_p0_oe = 1'b1;
    end
    // the read port was lent to the bus: hold the previous byte
    if (bus_st == BUS_MEM2) begin
      next_p0_out = port0_out;
      next_p0_oe = port0_oe;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_out <= ERASED_BYTE;
      port0_oe <= 1'b0;
      ea_latched <= 1'b0;
      ea_caught <= 1'b0;
      ea_effective <= 1'b0;
      table_read_blocked <= 1'b0;
      exec_external_disable <= 1'b0;
      data_ram_deny <= 1'b0;
    end else if (ce) begin
      port0_out <= next_p0_out;
      port0_oe <= next_p0_oe;
      ea_latched <= next_ea_latched;
      ea_caught <= next_ea_caught;
      ea_effective <= lock_any ? ea_latched : pins.external_access_level;
      table_read_blocked <= tbl_block;
      exec_external_disable <= ext_dis;
      data_ram_deny <= ext_dis;
    end
  end

endmodule : epv_top

//--- tb/epv_checker.sv
// checker: port-level properties of the program/verify port
`timescale 1ns/1ps
module epv_checker #(
  parameter logic [7:0] ID_BYTE0 = 8'hA5, // arbitrary identity value
  parameter logic [7:0] ID_BYTE1 = 8'h5A  // arbitrary identity value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire epv_pkg::epv_pins_t pins,
  input wire logic [7:0] port0_out,
  input wire logic port0_oe,
  input wire logic exec_external_disable,
  input wire logic data_ram_deny,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  import epv_pkg::*;
  // --------------------
  // read-mode decode seen from the pins
  // --------------------
  logic rd_lvl;
  logic sig_mode;
  logic vfy_mode;
  logic [11:0] pin_addr;
  logic [3:0] sel;
  assign sel = {pins.port2_bit_seven, pins.port2_bit_six,
                pins.port3_bit_seven, pins.port3_bit_six};
  assign rd_lvl = pins.reset_pin && !pins.program_store_enable &&
                  !pins.external_access_program_voltage &&
                  pins.external_access_level;
  assign sig_mode = rd_lvl && (sel == 4'h0);
  assign vfy_mode = rd_lvl && (sel == 4'h3);
  assign pin_addr = {pins.port2_addr, pins.port1};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // --------------------
  // properties; five cycles cover the three-cycle read path
  // --------------------
  a_oe_read_only: assert property (
    !(sig_mode || vfy_mode) [*5] |-> !port0_oe)
    else $error("stray port 0 drive");
  a_sig_first: assert property (
    (ce && sig_mode && pin_addr == SIG_ADDR0) [*5]
    |-> port0_oe && port0_out == ID_BYTE0)
    else $error("first id byte wrong");
  a_sig_second: assert property (
    (ce && sig_mode && pin_addr == SIG_ADDR1) [*5]
    |-> port0_oe && port0_out == ID_BYTE1)
    else $error("second id byte wrong");
  a_sig_other_off: assert property (
    (ce && sig_mode && pin_addr != SIG_ADDR0 && pin_addr != SIG_ADDR1) [*5]
    |-> !port0_oe)
    else $error("port 0 driven at other address");
  a_verify_locked: assert property (
    (ce && vfy_mode && exec_external_disable) [*5] |-> !port0_oe)
    else $error("verify output while locked");
  a_lock3_pair: assert property (
    exec_external_disable == data_ram_deny)
    else $error("lock three outputs disagree");
  a_wait_one: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_bound: assert property (
    $rose(avs_read || avs_write) |-> ##[1:3] !avs_waitrequest)
    else $error("bus answer late");
endmodule : epv_checker

bind epv_top epv_checker #(.ID_BYTE0(ID_BYTE0), .ID_BYTE1(ID_BYTE1)) u_chk (
  .clk(clk), .rst_n(rst_n), .ce(ce), .pins(pins),
  .port0_out(port0_out), .port0_oe(port0_oe),
  .exec_external_disable(exec_external_disable),
  .data_ram_deny(data_ram_deny), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

//--- tb/epv_prog_model.sv
// partner: external programming and verification system
`timescale 1ns/1ps
module epv_prog_model #(
  parameter int LOW_CYC = 22,
  parameter int HIGH_CYC = 4
) (
  input wire logic clk,
  input wire logic [7:0] port0_out,
  input wire logic port0_oe,
  output epv_pkg::epv_pins_t pins
);
  import epv_pkg::*;
  // pull-ups on port 0 when the device does not drive
  logic [7:0] p0;
  assign p0 = port0_oe ? port0_out : 8'hFF;

  // idle levels at time zero
  initial begin
    pins = '0;
    pins.reset_pin = 1'b1;
    pins.address_latch_program_strobe = 1'b1;
    pins.external_access_level = 1'b1;
    pins.port0_in = 8'hFF;
  end

  // static mode levels, address and data
  task automatic set_mode(input logic [3:0] sel, input logic [11:0] a,
                          input logic [7:0] d, input logic prog);
    @(posedge clk);
    pins.reset_pin <= 1'b1;
    pins.program_store_enable <= 1'b0;
    pins.external_access_program_voltage <= prog;
    pins.external_access_level <= 1'b1;
    {pins.port2_bit_seven, pins.port2_bit_six,
     pins.port3_bit_seven, pins.port3_bit_six} <= sel;
    {pins.port2_addr, pins.port1} <= a;
    pins.port0_in <= prog ? d : 8'hFF;
  endtask : set_mode

  // pulse train; low time scaled, levels held throughout
  task automatic write_byte(input logic [3:0] sel, input logic [11:0] a,
                            input logic [7:0] d, input int pulses);
    set_mode(sel, a, d, 1'b1);
    repeat (4) @(posedge clk);
    repeat (pulses) begin
      pins.address_latch_program_strobe <= 1'b0;
      repeat (LOW_CYC) @(posedge clk);
      pins.address_latch_program_strobe <= 1'b1;
      repeat (HIGH_CYC) @(posedge clk);
    end
  endtask : write_byte

  // read modes; sampled well after the read latency
  task automatic read_byte(input logic [3:0] sel, input logic [11:0] a,
                           output logic [7:0] d, output logic oe);
    set_mode(sel, a, 8'hFF, 1'b0);
    repeat (6) @(posedge clk);
    d = p0;
    oe = port0_oe;
  endtask : read_byte
endmodule : epv_prog_model

//--- tb/tb.sv
// testbench: program, encrypt, lock and verify through pins and bus
`timescale 1ns/1ps
module tb;
  import epv_pkg::*;
  localparam int LOW_MIN = 20;
  localparam logic [7:0] ID0 = 8'hC3; // arbitrary identity value
  localparam logic [7:0] ID1 = 8'h3C; // arbitrary identity value
  logic clk, rst_n, port0_oe, ea_effective, table_read_blocked;
  logic exec_external_disable, data_ram_deny, avs_read, avs_write;
  logic avs_waitrequest, oe;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] port0_out, d;
  logic [11:0] a;
  epv_pins_t pins;
  int num_errors, n_checks, cyc, seed;
  logic [7:0] code [4096] = '{default: 8'hFF};
  logic [7:0] key [64] = '{default: 8'hFF};
  logic [11:0] alist [5];

  epv_top #(.PROG_LOW_MIN(LOW_MIN), .ID_BYTE0(ID0), .ID_BYTE1(ID1)) DUT (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .pins(pins),
    .port0_out(port0_out), .port0_oe(port0_oe),
    .ea_effective(ea_effective), .table_read_blocked(table_read_blocked),
    .exec_external_disable(exec_external_disable),
    .data_ram_deny(data_ram_deny), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  epv_prog_model #(.LOW_CYC(LOW_MIN + 2), .HIGH_CYC(4)) PM (
    .clk(clk), .port0_out(port0_out), .port0_oe(port0_oe), .pins(pins));

  // --------------------
  // clock, timeout and reporting
  // --------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // a hang counts as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic chk_word(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic chk_byte(input string nm, input logic [7:0] e, g);
    chk_word(nm, {24'h0, e}, {24'h0, g});
  endtask : chk_byte
  task automatic chk_bit(input string nm, input logic e, g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask : chk_bit

  // --------------------
  // bus master, verify read and expectation
  // --------------------
  // only the bench timeout ends a wait
  task automatic bus(input logic wr, input logic [3:0] ad,
                     input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= ad;
    avs_writedata <= wd;
    do @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    chk_bit("bus answer", 1'b0, avs_waitrequest);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // stored byte seen through one table byte
  function automatic logic [7:0] exp_vfy(input logic [11:0] x);
    return ~(code[x] ^ key[x[5:0]]);
  endfunction : exp_vfy
  task automatic vfy(input logic [11:0] x, input logic drive);
    PM.read_byte(4'h3, x, d, oe);
    chk_bit("verify drive", drive, oe);
    if (drive) chk_byte("verify data", exp_vfy(x), d);
  endtask : vfy
  task automatic sig(input logic [11:0] x, input logic drive,
                     input logic [7:0] e);
    PM.read_byte(4'h0, x, d, oe);
    chk_bit("signature drive", drive, oe);
    if (drive) chk_byte("signature byte", e, d);
  endtask : sig
  task automatic lock_chk(input logic [3:0] sel, input logic [2:0] e);
    PM.write_byte(sel, 12'h000, 8'h00, 5);
    bus(1'b0, REG_STATUS, 32'h0, rd);
    chk_word("lock bits", {29'h0, e}, {29'h0, rd[2:0]});
  endtask : lock_chk

  // --------------------
  // main sequence
  // --------------------
  initial begin
    seed = 32'h4a39;
    {num_errors, n_checks, cyc} = '0;
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // register reset values, write-only and unmapped places
    bus(1'b1, 4'h2, 32'($random(seed)), rd);
    foreach (alist[i]) begin
      bus(1'b0, 4'(4 * i + 2 * (i / 4)), 32'h0, rd);
      if (i < 3) chk_word("reg reset", 32'h0, rd & 32'h0001_FF3F);
    end
    vfy(12'($random(seed)), 1'b1);
    // code bytes, both ends of the array among them
    foreach (alist[i]) begin
      a = (i == 0) ? CODE_LAST : (i == 1) ? 12'h000 : 12'($random(seed));
      alist[i] = a;
      code[a] = 8'($random(seed));
      PM.write_byte(4'hB, a, code[a], 5);
      vfy(a, 1'b1);
    end
    // four pulses must not commit
    PM.write_byte(4'hB, a, ~code[a], 4);
    vfy(a, 1'b1);
    sig(SIG_ADDR0, 1'b1, ID0);
    sig(SIG_ADDR1, 1'b1, ID1);
    sig(12'h032, 1'b0, 8'h00);
    // table load over 0 to 1F, then every byte verified; FFF still sees erased table byte 3F
    for (int k = 0; k < 32; k++) begin
      key[k] = 8'($random(seed));
      PM.write_byte(4'hA, 12'(k), key[k], 5);
    end
    foreach (alist[i]) vfy(alist[i], 1'b1);
    // the bus shows the raw byte, never the table
    bus(1'b1, REG_TADDR, {20'h0, alist[1]}, rd);
    bus(1'b0, REG_TDATA, 32'h0, rd);
    chk_word("raw byte", {24'h0, code[alist[1]]}, {23'h0, rd[8:0]});
    lock_chk(4'hF, 3'h1);
    PM.write_byte(4'hB, alist[2], ~code[alist[2]], 5);
    vfy(alist[2], 1'b1);
    bus(1'b0, REG_STATUS, 32'h0, rd);
    chk_bit("refused", 1'b1, rd[ST_REFUSED]);
    bus(1'b1, REG_TADDR, {15'h0, 1'b1, 4'h0, alist[2]}, rd);
    bus(1'b0, REG_TDATA, 32'h0, rd);
    chk_word("blocked read", 32'h100, {23'h0, rd[8:0]});
    chk_bit("table block", 1'b1, table_read_blocked);
    chk_bit("access latch", 1'b1, ea_effective);
    lock_chk(4'hC, 3'h3);
    vfy(alist[0], 1'b0);
    chk_bit("exec off early", 1'b0, exec_external_disable);
    lock_chk(4'h5, 3'h7);
    sig(SIG_ADDR0, 1'b1, ID0);
    // a second reset leaves the locks in place
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    vfy(alist[3], 1'b0);
    chk_bit("exec off", 1'b1, exec_external_disable);
    chk_bit("ram off", 1'b1, data_ram_deny);
    stop_test();
  end
endmodule : tb
